// file: ibt_buf2.sv
// Two-entry buffer for capture records, with valid and ready on both sides.
// A word offered while in_ready_o is low is dropped, not stored; read data come from a register.
`timescale 1ns/1ps
module ibt_buf2 (
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Filling side.
   input wire logic in_valid_i,
   input ibt_pkg::ibt_cap_t in_data_i,
   output logic in_ready_o,
   // Draining side.
   output logic out_valid_o,
   output ibt_pkg::ibt_cap_t out_data_o,
   input wire logic out_ready_i
);

   ibt_pkg::ibt_buf_t st_reg;
   ibt_pkg::ibt_buf_t st_next;

   always_comb begin
      logic push;
      logic pop;
      push = 1'b0;
      pop = 1'b0;
      st_next = st_reg;
      push = in_valid_i & st_reg.ready;
      pop = st_reg.valid & out_ready_i;
      if (push && pop) begin
         if (st_reg.count == ibt_pkg::IBT_CNT_ONE) begin
            st_next.head = in_data_i;
         end else begin
            st_next.head = st_reg.spare;
            st_next.spare = in_data_i;
         end
      end else if (pop) begin
         st_next.head = st_reg.spare;
         st_next.count = st_reg.count - ibt_pkg::IBT_CNT_ONE;
      end else if (push) begin
         if (st_reg.count == ibt_pkg::IBT_CNT_EMPTY) begin
            st_next.head = in_data_i;
         end else begin
            st_next.spare = in_data_i;
         end
         st_next.count = st_reg.count + ibt_pkg::IBT_CNT_ONE;
      end
      st_next.valid = (st_next.count != ibt_pkg::IBT_CNT_EMPTY);
      st_next.ready = (st_next.count != ibt_pkg::IBT_CNT_FULL);
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= '{head: ibt_pkg::IBT_CAP_RST, spare: ibt_pkg::IBT_CAP_RST,
                     count: ibt_pkg::IBT_CNT_EMPTY, valid: 1'b0, ready: 1'b1};
      end else begin
         st_reg <= st_next;
      end
   end

   assign in_ready_o = st_reg.ready;
   assign out_valid_o = st_reg.valid;
   assign out_data_o = st_reg.head;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_buf_full_stall: assert property ((st_reg.count == ibt_pkg::IBT_CNT_FULL) |-> !in_ready_o)
      else $error("buffer offers room while holding two words");
   a_buf_held_word: assert property ((out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_data_o)))
      else $error("stalled head word changed or vanished");

endmodule // ibt_buf2

// file: ibt_bus_agent.sv
// Behavioural model of the agents on the A and B buses.
// Assumes the bench names the value each agent wants to place; the agent yields to the device's enables.
`timescale 1ns/1ps
module ibt_bus_agent (
   // Device drive side.
   input wire logic [15:0] a_o,
   input wire logic [15:0] a_oe_o,
   input wire logic [15:0] b_o,
   input wire logic [15:0] b_oe_o,
   // Values the agents want on the buses.
   input wire logic [15:0] a_drv_i,
   input wire logic [15:0] b_drv_i,
   // Resolved wire levels.
   output logic [15:0] a_i,
   output logic [15:0] b_i
);
   // An agent keeps off every bit that the device is driving.
   assign a_i = (a_oe_o & a_o) | (~a_oe_o & a_drv_i);
   assign b_i = (b_oe_o & b_o) | (~b_oe_o & b_drv_i);
endmodule // ibt_bus_agent

// file: ibt_pkg.sv
// Constants, carrier structs and state layouts of the inverting registered bus transceiver.
// Assumes one system clock; every pin input is asynchronous to it and is synchronised inside the top module.
//
// Overview of operation
// - Two independent 8-bit sections, usable as 16 bits.
// - Capture clock rising edges load port into register.
// - Enabled: direction low drives A, high drives B.
// - Isolation leaves both ports undriven, capture continues.
// - Input-port value capturable into either or both registers.
// - Select picks live or stored data, glitch free.
// - Disabled outputs never block capture or later transmit.
// - Only one port driven; partner avoids it.
// - A port gets inverted live B data.
// - A port gets inverted stored B data.
// - B port gets inverted live A data.
// - B port gets inverted stored A data.
// - Capture ignores output enable and direction settings.
package ibt_pkg;

   localparam int unsigned IBT_SEC_W = 8;
   localparam int unsigned IBT_NSEC = 2;
   localparam int unsigned IBT_BUS_W = 16;
   localparam int unsigned IBT_CAP_PER_SEC = 2;
   localparam int unsigned IBT_MASK_W = 4;

   localparam logic [1:0] IBT_CNT_EMPTY = 2'h0;
   localparam logic [1:0] IBT_CNT_ONE = 2'h1;
   localparam logic [1:0] IBT_CNT_FULL = 2'h2;
   localparam logic [15:0] IBT_DATA_RST = 16'h0000;
   localparam logic [1:0] IBT_OE_N_RST = 2'h3;

   // All pin inputs travel together through the synchroniser.
   typedef struct packed {
      logic [1:0] oe_n;
      logic [1:0] dir;
      logic [1:0] a_to_b_capture_clock;
      logic [1:0] b_to_a_capture_clock;
      logic [1:0] a_to_b_source_select;
      logic [1:0] b_to_a_source_select;
      logic [15:0] a;
      logic [15:0] b;
   } ibt_pin_t;

   // One capture event: which registers loaded, and their new contents.
   typedef struct packed {
      logic [3:0] mask;
      logic [15:0] a;
      logic [15:0] b;
   } ibt_cap_t;

   typedef struct packed {
      ibt_pin_t s1;
      ibt_pin_t s2;
      ibt_pin_t s3;
      ibt_pin_t filt;
      logic [15:0] areg;
      logic [15:0] breg;
      logic [15:0] a_out;
      logic [15:0] a_oe;
      logic [15:0] b_out;
      logic [15:0] b_oe;
      ibt_cap_t cap;
      logic cap_push;
   } ibt_state_t;

   typedef struct packed {
      ibt_cap_t head;
      ibt_cap_t spare;
      logic [1:0] count;
      logic valid;
      logic ready;
   } ibt_buf_t;

   localparam ibt_pin_t IBT_PIN_RST = '{oe_n: IBT_OE_N_RST, default: '0};
   localparam ibt_cap_t IBT_CAP_RST = '{default: '0};

endpackage

// file: ibt_top.sv
// Inverting registered bus transceiver: two 8-bit sections, each with an A-side and a B-side capture register.
// Assumes every pin input is asynchronous to sys_clk_i and that pins are resolved from the output enables outside.
`timescale 1ns/1ps
module ibt_top (
   // Clock and reset.
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Per-section controls, bit s for section s.
   input wire logic [1:0] oe_n_i,
   input wire logic [1:0] dir_i,
   input wire logic [1:0] a_to_b_capture_clock_i,
   input wire logic [1:0] b_to_a_capture_clock_i,
   input wire logic [1:0] a_to_b_source_select_i,
   input wire logic [1:0] b_to_a_source_select_i,
   // A port.
   input wire logic [15:0] a_i,
   output logic [15:0] a_o,
   output logic [15:0] a_oe_o,
   // B port.
   input wire logic [15:0] b_i,
   output logic [15:0] b_o,
   output logic [15:0] b_oe_o,
   // Capture record stream.
   output logic cap_valid_o,
   output ibt_pkg::ibt_cap_t cap_data_o,
   input wire logic cap_ready_i,
   output logic cap_room_o
);

   ibt_pkg::ibt_state_t st_reg;
   ibt_pkg::ibt_state_t st_next;
   ibt_pkg::ibt_pin_t pins_in;

   assign pins_in = '{oe_n: oe_n_i, dir: dir_i,
                      a_to_b_capture_clock: a_to_b_capture_clock_i,
                      b_to_a_capture_clock: b_to_a_capture_clock_i,
                      a_to_b_source_select: a_to_b_source_select_i,
                      b_to_a_source_select: b_to_a_source_select_i,
                      a: a_i, b: b_i};

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Synchroniser, capture and output path.

   always_comb begin
      logic rise_ab;
      logic rise_ba;
      logic drv_a;
      logic drv_b;
      logic [7:0] src_a;
      logic [7:0] src_b;
      rise_ab = 1'b0;
      rise_ba = 1'b0;
      drv_a = 1'b0;
      drv_b = 1'b0;
      src_a = '0;
      src_b = '0;
      st_next = st_reg;
      st_next.s1 = pins_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // A filtered bit only moves once the second and third stages agree.
      st_next.filt = ibt_pkg::ibt_pin_t'((st_reg.s2 & st_reg.s3) | (st_reg.filt & (st_reg.s2 | st_reg.s3)));
      st_next.cap.mask = '0;
      for (int s = 0; s < ibt_pkg::IBT_NSEC; s++) begin
         rise_ab = st_next.filt.a_to_b_capture_clock[s] & ~st_reg.filt.a_to_b_capture_clock[s];
         rise_ba = st_next.filt.b_to_a_capture_clock[s] & ~st_reg.filt.b_to_a_capture_clock[s];
         // Capture looks at neither enable nor direction; the A register always loads from the A port, the B register from the B port.
         if (rise_ab) begin
            st_next.areg[s*ibt_pkg::IBT_SEC_W +: ibt_pkg::IBT_SEC_W] =
               st_next.filt.a[s*ibt_pkg::IBT_SEC_W +: ibt_pkg::IBT_SEC_W];
            st_next.cap.mask[s*ibt_pkg::IBT_CAP_PER_SEC] = 1'b1;
         end
         if (rise_ba) begin
            st_next.breg[s*ibt_pkg::IBT_SEC_W +: ibt_pkg::IBT_SEC_W] =
               st_next.filt.b[s*ibt_pkg::IBT_SEC_W +: ibt_pkg::IBT_SEC_W];
            st_next.cap.mask[s*ibt_pkg::IBT_CAP_PER_SEC + 1] = 1'b1;
         end
         // Only one direction can be enabled, chosen by the direction input.
         drv_a = ~st_next.filt.oe_n[s] & ~st_next.filt.dir[s];
         drv_b = ~st_next.filt.oe_n[s] & st_next.filt.dir[s];
         // The output flop after the select keeps a source change free of decode glitches.
         src_a = st_next.filt.b_to_a_source_select[s] ?
                 st_reg.breg[s*ibt_pkg::IBT_SEC_W +: ibt_pkg::IBT_SEC_W] :
                 st_next.filt.b[s*ibt_pkg::IBT_SEC_W +: ibt_pkg::IBT_SEC_W];
         src_b = st_next.filt.a_to_b_source_select[s] ?
                 st_reg.areg[s*ibt_pkg::IBT_SEC_W +: ibt_pkg::IBT_SEC_W] :
                 st_next.filt.a[s*ibt_pkg::IBT_SEC_W +: ibt_pkg::IBT_SEC_W];
         st_next.a_out[s*ibt_pkg::IBT_SEC_W +: ibt_pkg::IBT_SEC_W] = ~src_a;
         st_next.b_out[s*ibt_pkg::IBT_SEC_W +: ibt_pkg::IBT_SEC_W] = ~src_b;
         st_next.a_oe[s*ibt_pkg::IBT_SEC_W +: ibt_pkg::IBT_SEC_W] = {ibt_pkg::IBT_SEC_W{drv_a}};
         st_next.b_oe[s*ibt_pkg::IBT_SEC_W +: ibt_pkg::IBT_SEC_W] = {ibt_pkg::IBT_SEC_W{drv_b}};
      end
      st_next.cap.a = st_next.areg;
      st_next.cap.b = st_next.breg;
      st_next.cap_push = |st_next.cap.mask;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= '{s1: ibt_pkg::IBT_PIN_RST, s2: ibt_pkg::IBT_PIN_RST, s3: ibt_pkg::IBT_PIN_RST,
                     filt: ibt_pkg::IBT_PIN_RST, areg: ibt_pkg::IBT_DATA_RST, breg: ibt_pkg::IBT_DATA_RST,
                     a_out: ibt_pkg::IBT_DATA_RST, a_oe: ibt_pkg::IBT_DATA_RST,
                     b_out: ibt_pkg::IBT_DATA_RST, b_oe: ibt_pkg::IBT_DATA_RST,
                     cap: ibt_pkg::IBT_CAP_RST, cap_push: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign a_o = st_reg.a_out;
   assign a_oe_o = st_reg.a_oe;
   assign b_o = st_reg.b_out;
   assign b_oe_o = st_reg.b_oe;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Capture record buffer; a record offered without room is dropped, which cap_room_o warns of.

   ibt_buf2 u_buf (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(st_reg.cap_push),
      .in_data_i(st_reg.cap),
      .in_ready_o(cap_room_o),
      .out_valid_o(cap_valid_o),
      .out_data_o(cap_data_o),
      .out_ready_i(cap_ready_i)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Checks on section 0, plus one on both sections against dual drive.

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_to_a(logic sel);
      (!oe_n_i[0] && !dir_i[0] && (b_to_a_source_select_i[0] == sel) && $stable(b_i[7:0])
       && $stable(b_to_a_capture_clock_i[0]))[*5];
   endsequence

   sequence s_to_b(logic sel);
      (!oe_n_i[0] && dir_i[0] && (a_to_b_source_select_i[0] == sel) && $stable(a_i[7:0])
       && $stable(a_to_b_capture_clock_i[0]))[*5];
   endsequence

   sequence s_rise_ab;
      (!a_to_b_capture_clock_i[0] && $stable(a_i[7:0]))[*3] ##1
      (a_to_b_capture_clock_i[0] && $stable(a_i[7:0]))[*4];
   endsequence

   a_no_dual_drive: assert property ((a_oe_o & b_oe_o) == 16'h0000)
      else $error("both ports driven at once");
   a_iso_undriven: assert property (oe_n_i[0][*5] |=> (a_oe_o[7:0] == 8'h00 && b_oe_o[7:0] == 8'h00))
      else $error("port driven in isolation");
   a_dir_selects: assert property ((!oe_n_i[0] && !dir_i[0])[*5] |=> (a_oe_o[7:0] == 8'hFF && b_oe_o[7:0] == 8'h00))
      else $error("direction low did not drive A alone");
   a_live_b_inv: assert property (s_to_a(1'b0) |=> (a_o[7:0] == ~$past(b_i[7:0])))
      else $error("A port not inverted live B");
   a_stored_b_inv: assert property (s_to_a(1'b1) |=> (a_o[7:0] == ~st_reg.breg[7:0]))
      else $error("A port not inverted stored B");
   a_live_a_inv: assert property (s_to_b(1'b0) |=> (b_o[7:0] == ~$past(a_i[7:0])))
      else $error("B port not inverted live A");
   a_stored_a_inv: assert property (s_to_b(1'b1) |=> (b_o[7:0] == ~st_reg.areg[7:0]))
      else $error("B port not inverted stored A");
   a_capture_a: assert property (s_rise_ab |=> (st_reg.areg[7:0] == $past(a_i[7:0])))
      else $error("A register missed a capture edge");
   a_hold_a: assert property ((!a_to_b_capture_clock_i[0])[*4] |=> $stable(st_reg.areg[7:0]))
      else $error("A register changed without a capture edge");

endmodule // ibt_top

// file: testbench.sv
// Self-checking bench of the inverting registered bus transceiver.
// Assumes ibt_top, ibt_pkg and the bus agent model are compiled first.
`timescale 1ns/1ps
module testbench;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [1:0] oe_n_i = 2'h3, dir_i = 2'h0, ab_clk = 2'h0, ba_clk = 2'h0, ab_sel = 2'h0, ba_sel = 2'h0;
   logic [15:0] a_i, a_o, a_oe_o, b_i, b_o, b_oe_o;
   logic [15:0] a_drv = 16'h0000, b_drv = 16'h0000;
   logic cap_valid_o, cap_ready_i = 1'b0, cap_room_o;
   ibt_pkg::ibt_cap_t cap_data_o;
   int fails = 0, comparisons = 0;
   ////////////////////////////////////////////////////////////////////////////
   ibt_top i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .oe_n_i(oe_n_i), .dir_i(dir_i),
      .a_to_b_capture_clock_i(ab_clk), .b_to_a_capture_clock_i(ba_clk), .a_to_b_source_select_i(ab_sel),
      .b_to_a_source_select_i(ba_sel), .a_i(a_i), .a_o(a_o), .a_oe_o(a_oe_o), .b_i(b_i), .b_o(b_o),
      .b_oe_o(b_oe_o), .cap_valid_o(cap_valid_o), .cap_data_o(cap_data_o), .cap_ready_i(cap_ready_i),
      .cap_room_o(cap_room_o));
   ibt_bus_agent i_agent (.a_o(a_o), .a_oe_o(a_oe_o), .b_o(b_o), .b_oe_o(b_oe_o), .a_drv_i(a_drv),
      .b_drv_i(b_drv), .a_i(a_i), .b_i(b_i));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      if (fails == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Lets the bus data settle, then pulses the selected capture clocks long enough to pass the filter.
   task automatic cap_pulse(input logic [1:0] ab, input logic [1:0] ba);
      cyc(4);
      ab_clk = ab;
      ba_clk = ba;
      cyc(5);
      ab_clk = 2'h0;
      ba_clk = 2'h0;
      cyc(6);
   endtask
   task automatic pop;
      cap_ready_i = 1'b1;
      cyc(1);
      cap_ready_i = 1'b0;
      cyc(2);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Isolated ports still capture both registers of both sections at once.
   task automatic t_isolation;
      a_drv = 16'h1234;
      b_drv = 16'hABCD;
      cap_pulse(2'h3, 2'h3);
      chk(a_oe_o, 16'h0000);
      chk(b_oe_o, 16'h0000);
      chk(cap_valid_o, 1'b1);
      chk(cap_data_o, {4'hF, 16'h1234, 16'hABCD});
      pop();
      chk(cap_valid_o, 1'b0);
   endtask
   // Stored and live data, inverted, with the buses since changed.
   task automatic t_transfer;
      a_drv = 16'h5555;
      b_drv = 16'h3333;
      oe_n_i = 2'h0;
      dir_i = 2'h3;
      ab_sel = 2'h3;
      cyc(8);
      chk(b_o, 16'hEDCB);
      chk(b_oe_o, 16'hFFFF);
      chk(a_oe_o, 16'h0000);
      ab_sel = 2'h0;
      cyc(8);
      chk(b_o, 16'hAAAA);
      dir_i = 2'h0;
      ba_sel = 2'h3;
      // Long enough for the B port to settle after release and then stand five cycles.
      cyc(12);
      chk(a_o, 16'h5432);
      chk(b_oe_o, 16'h0000);
      ba_sel = 2'h0;
      cyc(8);
      chk(a_o, 16'hCCCC);
      dir_i = 2'h1;
      cyc(8);
      chk(b_oe_o, 16'h00FF);
      chk(a_oe_o, 16'hFF00);
      chk({a_o[15:8], b_o[7:0]}, 16'hCCAA);
      oe_n_i = 2'h3;
   endtask
   // Records pile up while the drain stalls; the overflowing one is dropped.
   task automatic t_buffer;
      a_drv = 16'h0011;
      cap_pulse(2'h1, 2'h0);
      a_drv = 16'h0022;
      cap_pulse(2'h1, 2'h0);
      chk(cap_room_o, 1'b0);
      a_drv = 16'h0033;
      cap_pulse(2'h1, 2'h0);
      chk(cap_data_o, {4'h1, 16'h1211, 16'hABCD});
      pop();
      chk(cap_data_o, {4'h1, 16'h1222, 16'hABCD});
      pop();
      chk(cap_valid_o, 1'b0);
      chk(cap_room_o, 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(8);
      rst_n_i = 1'b1;
      cyc(4);
      t_isolation();
      t_transfer();
      t_buffer();
      stop_test();
   end
   // The tests take about 125 cycles.
   initial begin
      #20000;
      fails++;
      stop_test();
   end
endmodule // testbench
